// ### src/iak_pkg.sv
// What this block does
// - Unglued external chain devices sit above on-chip units.
// - External device passes chain change within two clocks.
// - Acknowledge cycle carries five wait states in total.
// - Serial acknowledge strobe falls at first state's fall.
// - Serial read strobe falls at fourth wait's rise.
// - Timer request strobe falls with serial read strobe.
// - External request strobe falls at first auto wait.
// - External chain settles before timer request strobe.
// - Lower-priority external device needs delayed request strobe.
// - Fetch strobe leads request strobe by two and a half periods.
package iak_pkg;

  localparam int DATA_W = 8;
  localparam int SYS_PER_BUS = 2;
  localparam int AUTO_WAITS = 2;
  localparam int ADDED_WAITS = 3;
  localparam int TOTAL_WAITS = AUTO_WAITS + ADDED_WAITS;
  localparam int FETCH_LEAD_BUS = 2;
  localparam int CHAIN_PROP_MAX_CYC = 2;

  // Position inside the cycle counts system clocks from the rise of the first bus state.
  localparam logic [3:0] POS_FETCH = 4'h0;
  localparam logic [3:0] POS_ACK = 4'h1;
  localparam logic [3:0] POS_EXT_IO = 4'h5;
  localparam logic [3:0] POS_RD = 4'ha;
  localparam logic [3:0] POS_LAST = 4'hf;

  localparam logic [7:0] VEC_RST = 8'h00;
  localparam logic [7:0] BUS_IDLE = 8'hff;

  // The usual path from idle to T3 is Gray coded so one bit flips per step; T3 back to idle flips two.
  typedef enum logic [3:0] {
    IAK_IDLE = 4'h0,
    IAK_T1 = 4'h1,
    IAK_T2 = 4'h3,
    IAK_TWA1 = 4'h2,
    IAK_TWA2 = 4'h6,
    IAK_TW3 = 4'h7,
    IAK_TW4 = 4'h5,
    IAK_TW5 = 4'h4,
    IAK_T3 = 4'hc
  } iak_bus_e;

endpackage : iak_pkg

// ### src/iak_chain_if.sv
`timescale 1ns/1ns
interface iak_chain_if;
  import iak_pkg::*;

  logic fetch_n;
  logic io_req_n;
  logic ext_chain_out;
  logic [DATA_W-1:0] ext_data;
  logic ext_data_oe;
  logic [DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic [DATA_W-1:0] data_bus;

  // Shared data bus level worked out from the two enables; pulled high when idle.
  assign data_bus = ext_data_oe ? ext_data : (dev_data_oe ? dev_data : BUS_IDLE);

  modport dev (
    output fetch_n,
    output io_req_n,
    output dev_data,
    output dev_data_oe,
    input ext_chain_out,
    input data_bus
  );

  modport per (
    input fetch_n,
    input io_req_n,
    input data_bus,
    output ext_chain_out,
    output ext_data,
    output ext_data_oe
  );

endinterface : iak_chain_if

// ### src/iak_ack_seq.sv
`timescale 1ns/1ns
module iak_ack_seq (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Core side.
  input wire logic ack_start_i,
  output logic ack_busy_o,
  output logic ack_done_o,
  output logic vec_valid_o,
  output logic vec_ext_o,
  output logic [iak_pkg::DATA_W-1:0] vec_o,
  // On-chip serial unit.
  input wire logic scu_pending_i,
  input wire logic [iak_pkg::DATA_W-1:0] scu_vector_i,
  output logic scu_ack_n_o,
  output logic scu_rd_n_o,
  // On-chip counter/timer unit.
  input wire logic ctu_pending_i,
  input wire logic [iak_pkg::DATA_W-1:0] ctu_vector_i,
  output logic ctu_io_req_n_o,
  // External chain.
  iak_chain_if.dev chain
);
  import iak_pkg::*;

  initial begin
    if (TOTAL_WAITS != 5 || AUTO_WAITS != 2) begin
      $error("iak_ack_seq: state sequence serves exactly two plus three wait states");
    end
    if (int'(POS_EXT_IO) - int'(POS_FETCH) < FETCH_LEAD_BUS * SYS_PER_BUS) begin
      $error("iak_ack_seq: fetch strobe lead too short");
    end
  end

  // State and phase; phase 0 is the rising half of a bus state, phase 1 the falling half.
  iak_bus_e st_r;
  iak_bus_e st_nxt;
  logic ph_r;
  logic ph_nxt;

  // Registered strobes, all active low.
  logic fetch_n_r;
  logic ack_n_r;
  logic eio_n_r;
  logic rd_n_r;

  // Chain and bus synchronisers.
  logic chain_q1_r;
  logic chain_q2_r;
  logic [DATA_W-1:0] data_q1_r;
  logic [DATA_W-1:0] data_q2_r;

  // Winner of the chain, captured at the read strobe edge.
  logic win_scu_r;
  logic win_ctu_r;
  logic win_ext_r;

  // Bus drive and results.
  logic [DATA_W-1:0] dev_data_r;
  logic dev_oe_r;
  logic [DATA_W-1:0] vec_r;
  logic vec_valid_r;
  logic vec_ext_r;
  logic done_r;

  function automatic logic [2:0] ord_of(input iak_bus_e s);
    logic [2:0] o;
    o = 3'h0;
    unique case (s)
      IAK_IDLE: o = 3'h0;
      IAK_T1: o = 3'h0;
      IAK_T2: o = 3'h1;
      IAK_TWA1: o = 3'h2;
      IAK_TWA2: o = 3'h3;
      IAK_TW3: o = 3'h4;
      IAK_TW4: o = 3'h5;
      IAK_TW5: o = 3'h6;
      IAK_T3: o = 3'h7;
      default: o = 3'h0;
    endcase
    return o;
  endfunction : ord_of

  // Bus state walk; each state lasts two system clocks.
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      IAK_IDLE: begin
        if (ack_start_i) begin
          st_nxt = IAK_T1;
        end
      end
      IAK_T1: begin
        if (ph_r) begin
          st_nxt = IAK_T2;
        end
      end
      IAK_T2: begin
        if (ph_r) begin
          st_nxt = IAK_TWA1;
        end
      end
      IAK_TWA1: begin
        if (ph_r) begin
          st_nxt = IAK_TWA2;
        end
      end
      IAK_TWA2: begin
        if (ph_r) begin
          st_nxt = IAK_TW3;
        end
      end
      IAK_TW3: begin
        if (ph_r) begin
          st_nxt = IAK_TW4;
        end
      end
      IAK_TW4: begin
        if (ph_r) begin
          st_nxt = IAK_TW5;
        end
      end
      IAK_TW5: begin
        if (ph_r) begin
          st_nxt = IAK_T3;
        end
      end
      IAK_T3: begin
        if (ph_r) begin
          st_nxt = IAK_IDLE;
        end
      end
      default: st_nxt = IAK_IDLE;
    endcase
  end

  wire run_r = (st_r != IAK_IDLE);
  wire run_nxt = (st_nxt != IAK_IDLE);
  assign ph_nxt = run_r & ~ph_r;
  wire [3:0] pos_nxt = {ord_of(st_nxt), ph_nxt};

  // Strobe decode from the next position so each strobe changes with the state register.
  wire fetch_n_nxt = ~(run_nxt && pos_nxt >= POS_FETCH);
  wire ack_n_nxt = ~(run_nxt && pos_nxt >= POS_ACK);
  wire eio_n_nxt = ~(run_nxt && pos_nxt >= POS_EXT_IO);
  wire rd_n_nxt = ~(run_nxt && pos_nxt >= POS_RD);
  wire rd_edge = rd_n_r & ~rd_n_nxt;
  wire last = run_r & ~run_nxt;

  // The external device above the on-chip units holds the chain low when it claims it.
  wire win_ext_nxt = ~chain_q2_r;
  wire win_scu_nxt = chain_q2_r & scu_pending_i;
  wire win_ctu_nxt = chain_q2_r & ~scu_pending_i & ctu_pending_i;
  wire win_int_r = win_scu_r | win_ctu_r;
  wire win_int_nxt = rd_edge ? (win_scu_nxt | win_ctu_nxt) : win_int_r;
  wire dev_oe_nxt = ~rd_n_nxt & win_int_nxt;
  wire [DATA_W-1:0] int_vec = win_scu_r ? scu_vector_i : ctu_vector_i;
  wire [DATA_W-1:0] res_vec = win_int_r ? int_vec : data_q2_r;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= IAK_IDLE;
      ph_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fetch_n_r <= 1'b1;
      ack_n_r <= 1'b1;
      eio_n_r <= 1'b1;
      rd_n_r <= 1'b1;
    end else begin
      fetch_n_r <= fetch_n_nxt;
      ack_n_r <= ack_n_nxt;
      eio_n_r <= eio_n_nxt;
      rd_n_r <= rd_n_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chain_q1_r <= 1'b1;
      chain_q2_r <= 1'b1;
      data_q1_r <= BUS_IDLE;
      data_q2_r <= BUS_IDLE;
    end else begin
      chain_q1_r <= chain.ext_chain_out;
      chain_q2_r <= chain_q1_r;
      data_q1_r <= chain.data_bus;
      data_q2_r <= data_q1_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      win_scu_r <= 1'b0;
      win_ctu_r <= 1'b0;
      win_ext_r <= 1'b0;
    end else if (rd_edge) begin
      win_scu_r <= win_scu_nxt;
      win_ctu_r <= win_ctu_nxt;
      win_ext_r <= win_ext_nxt;
    end else if (last) begin
      win_scu_r <= 1'b0;
      win_ctu_r <= 1'b0;
      win_ext_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dev_data_r <= BUS_IDLE;
      dev_oe_r <= 1'b0;
    end else begin
      dev_data_r <= rd_edge ? (win_scu_nxt ? scu_vector_i : ctu_vector_i) : int_vec;
      dev_oe_r <= dev_oe_nxt;
    end
  end

  // Results are taken at the close of the last bus state.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vec_r <= VEC_RST;
      vec_valid_r <= 1'b0;
      vec_ext_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= last;
      vec_valid_r <= last & (win_int_r | win_ext_r);
      if (last) begin
        vec_r <= res_vec;
        vec_ext_r <= win_ext_r;
      end
    end
  end

  assign ack_busy_o = ~fetch_n_r;
  assign ack_done_o = done_r;
  assign vec_valid_o = vec_valid_r;
  assign vec_ext_o = vec_ext_r;
  assign vec_o = vec_r;
  assign scu_ack_n_o = ack_n_r;
  assign scu_rd_n_o = rd_n_r;
  assign ctu_io_req_n_o = rd_n_r;
  assign chain.fetch_n = fetch_n_r;
  assign chain.io_req_n = eio_n_r;
  assign chain.dev_data = dev_data_r;
  assign chain.dev_data_oe = dev_oe_r;

endmodule : iak_ack_seq

// ### src/iak_chain_peer.sv
`timescale 1ns/1ns
module iak_chain_peer (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // User side.
  input wire logic req_i,
  input wire logic [iak_pkg::DATA_W-1:0] vector_i,
  input wire logic chain_in_i,
  output logic served_o,
  output logic holding_o,
  // Chain toward the sequencer.
  iak_chain_if.per chain
);
  import iak_pkg::*;

  initial begin
    if (CHAIN_PROP_MAX_CYC < 1) begin
      $error("iak_chain_peer: chain pass-through needs at least one cycle");
    end
  end

  logic fetch_q1_r;
  logic fetch_q2_r;
  logic fetch_q3_r;
  logic io_q1_r;
  logic io_q2_r;
  logic hold_r;
  logic chain_out_r;
  logic [DATA_W-1:0] data_r;
  logic oe_r;
  logic served_r;

  wire fetch_fall = fetch_q3_r & ~fetch_q2_r;
  wire fetch_rise = ~fetch_q3_r & fetch_q2_r;
  wire ack_cycle = ~fetch_q2_r;
  wire ack_active = ack_cycle & ~io_q2_r;
  // Request is frozen for the cycle so the chain stays settled.
  // On the freeze edge the live request still counts, so chain out does not blink high.
  wire pend = (ack_cycle & ~fetch_fall) ? hold_r : req_i;
  wire chain_out_nxt = chain_in_i & ~pend;
  wire oe_nxt = ack_active & hold_r;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fetch_q1_r <= 1'b1;
      fetch_q2_r <= 1'b1;
      fetch_q3_r <= 1'b1;
      io_q1_r <= 1'b1;
      io_q2_r <= 1'b1;
    end else begin
      fetch_q1_r <= chain.fetch_n;
      fetch_q2_r <= fetch_q1_r;
      fetch_q3_r <= fetch_q2_r;
      io_q1_r <= chain.io_req_n;
      io_q2_r <= io_q1_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_r <= 1'b0;
    end else if (fetch_fall) begin
      hold_r <= req_i & chain_in_i;
    end else if (fetch_rise) begin
      hold_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chain_out_r <= 1'b1;
      data_r <= BUS_IDLE;
      oe_r <= 1'b0;
      served_r <= 1'b0;
    end else begin
      chain_out_r <= chain_out_nxt;
      data_r <= vector_i;
      oe_r <= oe_nxt;
      served_r <= fetch_rise & hold_r;
    end
  end

  assign served_o = served_r;
  assign holding_o = hold_r;
  assign chain.ext_chain_out = chain_out_r;
  assign chain.ext_data = data_r;
  assign chain.ext_data_oe = oe_r;

endmodule : iak_chain_peer

// ### sim/iak_chain_properties.sv
`timescale 1ns/1ns
module iak_chain_properties (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Chain signals.
  input wire logic fetch_n,
  input wire logic io_req_n,
  input wire logic ext_chain_out,
  input wire logic ext_data_oe,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  fetch_span_a: assert property ($fell(fetch_n) |-> !fetch_n [*8] ##1 !fetch_n [*8] ##1 fetch_n)
    else $error("fetch strobe low span is not sixteen clocks");
  io_after_fetch_a: assert property ($fell(fetch_n) |-> ##5 $fell(io_req_n))
    else $error("request strobe did not fall five clocks after fetch");
  fetch_lead_a: assert property ($fell(io_req_n) |-> !$past(fetch_n, 4))
    else $error("fetch strobe lead before request strobe too short");
  strobes_release_a: assert property ($rose(fetch_n) |-> $rose(io_req_n))
    else $error("strobes not released together");
  data_mutex_a: assert property (!(ext_data_oe && dev_data_oe))
    else $error("both ends drive the data bus");
  ext_oe_delay_a: assert property ($rose(ext_data_oe) |-> !io_req_n && !$past(io_req_n, 2))
    else $error("peer drives data before request strobe settles");
  dev_oe_window_a: assert property (dev_data_oe |-> !fetch_n && !io_req_n)
    else $error("device drives data outside acknowledge");
  claim_chain_a: assert property (ext_data_oe && !fetch_n |-> !ext_chain_out)
    else $error("claiming peer leaves chain out high");
  ext_oe_release_a: assert property ($rose(fetch_n) |-> ##[1:4] !ext_data_oe)
    else $error("peer holds data bus after cycle end");
endmodule : iak_chain_properties

// ### sim/acknowledge_strobe_daisy_chain_sequencer_tb.sv
`timescale 1ns/1ns
module acknowledge_strobe_daisy_chain_sequencer_tb;
  import iak_pkg::*;

  logic clk_sys_i;
  logic nrst_i;
  logic ack_start_i;
  logic ack_busy_o;
  logic ack_done_o;
  logic vec_valid_o;
  logic vec_ext_o;
  logic [DATA_W-1:0] vec_o;
  logic scu_pending_i;
  logic [DATA_W-1:0] scu_vector_i;
  logic scu_ack_n_o;
  logic scu_rd_n_o;
  logic ctu_pending_i;
  logic [DATA_W-1:0] ctu_vector_i;
  logic ctu_io_req_n_o;
  logic req_i;
  logic [DATA_W-1:0] vector_i;
  logic served_o;
  logic holding_o;
  int err_count;
  int checks_done;

  iak_chain_if chain_if ();

  iak_ack_seq iak_ack_seq_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ack_start_i(ack_start_i),
    .ack_busy_o(ack_busy_o), .ack_done_o(ack_done_o), .vec_valid_o(vec_valid_o),
    .vec_ext_o(vec_ext_o), .vec_o(vec_o), .scu_pending_i(scu_pending_i),
    .scu_vector_i(scu_vector_i), .scu_ack_n_o(scu_ack_n_o), .scu_rd_n_o(scu_rd_n_o),
    .ctu_pending_i(ctu_pending_i), .ctu_vector_i(ctu_vector_i),
    .ctu_io_req_n_o(ctu_io_req_n_o), .chain(chain_if)
  );

  // The peer sits at the top of the chain, so its own chain input stays high.
  iak_chain_peer iak_chain_peer_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req_i), .vector_i(vector_i),
    .chain_in_i(1'b1), .served_o(served_o), .holding_o(holding_o), .chain(chain_if)
  );

  iak_chain_properties iak_chain_properties_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .fetch_n(chain_if.fetch_n),
    .io_req_n(chain_if.io_req_n), .ext_chain_out(chain_if.ext_chain_out),
    .ext_data_oe(chain_if.ext_data_oe), .dev_data_oe(chain_if.dev_data_oe)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // One acknowledge cycle, walked position by position from the accepting edge.
  task automatic run_ack(input logic sp, input logic cp, input logic pr, input logic ev,
                         input logic ee, input logic [7:0] evec);
    int p;
    @(posedge clk_sys_i);
    scu_pending_i <= sp;
    ctu_pending_i <= cp;
    req_i <= pr;
    ack_start_i <= 1'b1;
    @(posedge clk_sys_i);
    ack_start_i <= 1'b0;
    for (p = 0; p < 16; p++) begin
      if (p > 0) @(posedge clk_sys_i);
      #1;
      check(chain_if.fetch_n, 8'h00);
      check(scu_ack_n_o, p < 1);
      check(scu_rd_n_o, p < 10);
      check(ctu_io_req_n_o, p < 10);
      check(chain_if.io_req_n, p < 5);
      check(chain_if.ext_chain_out, !pr);
      check(ack_busy_o, 8'h01);
    end
    check(chain_if.ext_chain_out, !pr);
    check(holding_o, pr);
    check(chain_if.data_bus, ev ? evec : 8'hff);
    @(posedge clk_sys_i);
    #1;
    check(ack_done_o, 8'h01);
    check(chain_if.fetch_n, 8'h01);
    check(vec_valid_o, ev);
    check(vec_ext_o, ee);
    if (ev) check(vec_o, evec);
    check(ack_busy_o, 8'h00);
    repeat (3) @(posedge clk_sys_i);
    #1;
    check(served_o, pr);
    check(chain_if.ext_data_oe, 8'h00);
    @(posedge clk_sys_i);
    $display("test done at %0t", $time);
  endtask : run_ack

  initial begin
    nrst_i = 1'b0;
    ack_start_i = 1'b0;
    scu_pending_i = 1'b0;
    ctu_pending_i = 1'b0;
    req_i = 1'b0;
    scu_vector_i = 8'h5a;
    ctu_vector_i = 8'h3c;
    vector_i = 8'hc3;
    err_count = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    run_ack(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h5a);
    run_ack(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h3c);
    run_ack(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h5a);
    run_ack(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    run_ack(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'hc3);
    // A reset in mid-cycle, before the read strobe falls, must release the fetch, acknowledge and request strobes at once.
    @(posedge clk_sys_i);
    ack_start_i <= 1'b1;
    repeat (7) @(posedge clk_sys_i);
    ack_start_i <= 1'b0;
    nrst_i <= 1'b0;
    #1;
    check(chain_if.fetch_n, 8'h01);
    check(scu_ack_n_o, 8'h01);
    check(chain_if.io_req_n, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    $display("test done at %0t", $time);
    run_ack(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h5a);
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge clk_sys_i);
    err_count++;
    tally_and_finish();
  end
endmodule : acknowledge_strobe_daisy_chain_sequencer_tb
